// >>> sync_sram_pin_control.sv
// Control-pin behaviour of a synchronous flow-through burst SRAM
// Function
// - Sample third chip select on qualified load edges only
// - Output enable low lets data pins drive
// - Tri-state on write data, deselect exit
// - Qualifier high holds all state but mem_we_r and the sleep and strap synchronizers
// - Qualifier high never deselects the device
// - Sleep input enters low power, keeps array
// - Undriven sleep reads as deasserted
// - Capture data pins on rising edge
// - Reads drive data of sampled address
// - Parity lanes follow data, byte-write gated
// - Strap selects linear or interleaved burst
// - Low address bits feed two-bit counter
// - Chip selects: low, high, low polarity
// - Advance steps counter, load starts access
`timescale 1ns/1ps
`default_nettype none
`include "sram_ctl_defines.svh"
module sync_sram_pin_control #(
    parameter int AW    = 8,
    parameter int LANES = 4,
    parameter int LW    = 9
) (
    input  wire logic                    REF_CLK,
    input  wire logic                    RESETN,
    input  wire sram_ctl_pkg::ctl_pins_t CTL,
    input  wire logic                    CLK_QUALIFY_N,
    input  wire logic [AW-1:0]           ADDR,
    input  wire logic [LANES-1:0]        BYTE_WR_N,
    input  wire logic                    OUT_EN_N,
    input  wire logic                    SLEEP_REQ,
    input  wire logic                    SLEEP_REQ_OE,
    input  wire logic                    BURST_MODE,
    input  wire logic                    BURST_MODE_OE,
    input  wire logic [LANES*8-1:0]      DQ_I,
    output logic      [LANES*8-1:0]      DQ_O,
    output logic                         DQ_OE,
    input  wire logic [LANES-1:0]        PARITY_IO_I,
    output logic      [LANES-1:0]        PARITY_IO_O,
    output logic                         PARITY_IO_OE,
    output logic                         SLEEPING
);
    import sram_ctl_pkg::*;

    phase_t              phase_r, phase_nxt;
    logic [AW-1:0]       addr_r, addr_nxt;
    logic [1:0]          cnt_r, cnt_nxt;
    logic [1:0]          base_r, base_nxt;
    logic                first_r, first_nxt;
    logic [LANES-1:0]    lane_r, lane_nxt;
    logic [1:0]          zz_sync_r, zz_sync_nxt;
    logic [1:0]          mode_sync_r, mode_sync_nxt;
    logic [LANES*LW-1:0] wdata, rdata;
    logic                mem_we;
    logic [AW-1:0]       mem_addr, rd_addr;
    logic                sleep_lvl, edge_ok, selected, interleaved;
    logic                mem_we_r, mem_we_nxt;

    // Floating sleep pin reads low, like an internal pull-down
    assign sleep_lvl = SLEEP_REQ_OE & SLEEP_REQ;

    // Sleep and strap are pins, so each passes two flops first
    always_comb begin
        zz_sync_nxt   = {zz_sync_r[0], sleep_lvl};
        mode_sync_nxt = {mode_sync_r[0], BURST_MODE_OE ? BURST_MODE : ~`MODE_LINEAR};
        mem_we_nxt    = mem_we;
    end

    always_ff @(posedge REF_CLK) begin
        if (!RESETN) begin
            zz_sync_r <= `SLEEP_SYNC_RST;
            mem_we_r  <= 1'b0;
        end else begin
            zz_sync_r <= zz_sync_nxt;
            mem_we_r  <= mem_we_nxt;
        end
    end
    assign SLEEPING = zz_sync_r[1];

    // Strap keeps tracking through reset so a burst right after it is right
    always_ff @(posedge REF_CLK) begin
        mode_sync_r <= mode_sync_nxt;
    end

    // Floating strap counts as interleaved
    assign interleaved = (mode_sync_r[1] != `MODE_LINEAR);

    // Qualifier low gates every edge; sleep also freezes state
    assign edge_ok = !CLK_QUALIFY_N && !SLEEPING;

    // All three selects active, polarities low/high/low
    assign selected = !CTL.chip_sel_a_n && CTL.chip_sel_b && !CTL.chip_sel_c_n;

    // Burst address from base and counter, per strap order
    function automatic logic [1:0] burst_addr(input logic [1:0] b, input logic [1:0] c,
                                              input logic il);
        burst_addr = il ? (b ^ c) : 2'(b + c);
    endfunction : burst_addr

    // Access phase, address and burst counter next state
    always_comb begin
        phase_nxt = phase_r;
        addr_nxt  = addr_r;
        cnt_nxt   = cnt_r;
        base_nxt  = base_r;
        first_nxt = 1'b0;
        lane_nxt  = lane_r;
        if (edge_ok) begin
            if (!CTL.burst_step_or_load) begin
                if (selected) begin
                    phase_nxt = CTL.wr_n ? ST_READ : ST_WRITE;
                    addr_nxt  = ADDR;
                    base_nxt  = ADDR[`BURST_W-1:0];
                    cnt_nxt   = `BURST_ZERO;
                    first_nxt = (phase_r == ST_DESEL);
                end else begin
                    phase_nxt = ST_DESEL;
                end
            end else if (phase_r != ST_DESEL) begin
                cnt_nxt = 2'(cnt_r + `BURST_ONE);
            end
            lane_nxt = ~BYTE_WR_N;
        end else begin
            first_nxt = first_r;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RESETN) begin
            phase_r <= ST_DESEL;
            addr_r  <= '0;
            cnt_r   <= `BURST_ZERO;
            base_r  <= `BURST_ZERO;
            first_r <= 1'b0;
            lane_r  <= '0;
        end else begin
            phase_r <= phase_nxt;
            addr_r  <= addr_nxt;
            cnt_r   <= cnt_nxt;
            base_r  <= base_nxt;
            first_r <= first_nxt;
            lane_r  <= lane_nxt;
        end
    end

    // Write lands on the current beat; read looks ahead so data flows through
    assign mem_addr = {addr_r[AW-1:`BURST_W], burst_addr(base_r, cnt_r, interleaved)};
    assign rd_addr  = {addr_nxt[AW-1:`BURST_W], burst_addr(base_nxt, cnt_nxt, interleaved)};

    // Pack bytes with their parity bits into lanes
    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : g_pack
            assign wdata[g*LW +: LW]           = {PARITY_IO_I[g], DQ_I[g*`BYTE_W +: `BYTE_W]};
            assign DQ_O[g*`BYTE_W +: `BYTE_W]  = rdata[g*LW +: `BYTE_W];
            assign PARITY_IO_O[g]              = rdata[g*LW + `BYTE_W];
        end
    endgenerate

    // Write data taken on the edge after the write address
    assign mem_we = edge_ok && (phase_r == ST_WRITE);

    sram_array #(.AW(AW), .LANES(LANES), .LW(LW)) u_array (
        .clk     (REF_CLK),
        .we      (mem_we),
        .lane_en (lane_nxt),
        .addr    (rd_addr),
        .waddr   (mem_addr),
        .wdata   (wdata),
        .rdata   (rdata)
    );

    // Drive only on read, not first after deselect, not writing
    assign DQ_OE        = !OUT_EN_N && (phase_r == ST_READ) && !first_r && !SLEEPING;
    assign PARITY_IO_OE = DQ_OE;

    // Deselected phase never drives the pins
    property p_desel_tristate;
        @(posedge REF_CLK) disable iff (!RESETN)
        (phase_r == ST_DESEL) |-> !DQ_OE && !PARITY_IO_OE;
    endproperty
    a_desel_tristate: assert property (p_desel_tristate)
        else $error("data pins driven while deselected");

    property p_write_tristate;
        @(posedge REF_CLK) disable iff (!RESETN)
        (phase_r == ST_WRITE) |-> !DQ_OE;
    endproperty
    a_write_tristate: assert property (p_write_tristate)
        else $error("data pins driven during write");

    property p_oe_high_tristate;
        @(posedge REF_CLK) disable iff (!RESETN)
        OUT_EN_N |-> !DQ_OE;
    endproperty
    a_oe_high_tristate: assert property (p_oe_high_tristate)
        else $error("drive while output enable high");

    property p_hold_state;
        @(posedge REF_CLK) disable iff (!RESETN)
        CLK_QUALIFY_N |=> $stable(phase_r) && $stable(cnt_r) && $stable(addr_r);
    endproperty
    a_hold_state: assert property (p_hold_state)
        else $error("state moved on unqualified edge");

    property p_no_desel_on_hold;
        @(posedge REF_CLK) disable iff (!RESETN)
        (CLK_QUALIFY_N && phase_r != ST_DESEL) |=> (phase_r != ST_DESEL);
    endproperty
    a_no_desel_on_hold: assert property (p_no_desel_on_hold)
        else $error("qualifier deselected device");

    property p_select_all;
        @(posedge REF_CLK) disable iff (!RESETN)
        (edge_ok && !CTL.burst_step_or_load && CTL.chip_sel_c_n) |=> (phase_r == ST_DESEL);
    endproperty
    a_select_all: assert property (p_select_all)
        else $error("selected with third select inactive");

    property p_select_b;
        @(posedge REF_CLK) disable iff (!RESETN)
        (edge_ok && !CTL.burst_step_or_load && !CTL.chip_sel_b) |=> (phase_r == ST_DESEL);
    endproperty
    a_select_b: assert property (p_select_b)
        else $error("selected with second select low");

    property p_counter_step;
        @(posedge REF_CLK) disable iff (!RESETN)
        (edge_ok && CTL.burst_step_or_load && phase_r != ST_DESEL)
            |=> cnt_r == 2'($past(cnt_r) + `BURST_ONE);
    endproperty
    a_counter_step: assert property (p_counter_step)
        else $error("burst counter did not advance");

    property p_first_tristate;
        @(posedge REF_CLK) disable iff (!RESETN)
        (edge_ok && phase_r == ST_DESEL && selected && !CTL.burst_step_or_load)
            |=> !DQ_OE;
    endproperty
    a_first_tristate: assert property (p_first_tristate)
        else $error("drive in first clock after deselect");

    property p_sleep_freeze;
        @(posedge REF_CLK) disable iff (!RESETN)
        SLEEPING |=> !mem_we_r && $stable(phase_r);
    endproperty
    a_sleep_freeze: assert property (p_sleep_freeze)
        else $error("activity during sleep");
endmodule : sync_sram_pin_control
`default_nettype wire

// >>> sram_ctl_defines.svh
// Constants for the synchronous flow-through SRAM pin control block
`ifndef SRAM_CTL_DEFINES_SVH
`define SRAM_CTL_DEFINES_SVH
`define BURST_W        2
`define BYTE_W         8
`define BURST_ONE      2'h1
`define BURST_ZERO     2'h0
`define MODE_LINEAR    1'b0
`define SLEEP_SYNC_RST 2'h0
`endif

// >>> sram_ctl_pkg.sv
// Types shared by the SRAM pin control block
`default_nettype none
package sram_ctl_pkg;
    // Synchronous control pins sampled on a qualified edge
    typedef struct packed {
        logic chip_sel_a_n;
        logic chip_sel_b;
        logic chip_sel_c_n;
        logic burst_step_or_load;
        logic wr_n;
    } ctl_pins_t;

    // One-hot access phase
    typedef enum logic [2:0] {
        ST_DESEL = 3'h1,
        ST_READ  = 3'h2,
        ST_WRITE = 3'h4
    } phase_t;
endpackage : sram_ctl_pkg
`default_nettype wire

// >>> sram_array.sv
// Word memory with registered read data and per-lane write enables
`timescale 1ns/1ps
`default_nettype none
module sram_array #(
    parameter int AW    = 8,
    parameter int LANES = 4,
    parameter int LW    = 9
) (
    input  wire logic                  clk,
    input  wire logic                  we,
    input  wire logic [LANES-1:0]      lane_en,
    input  wire logic [AW-1:0]         addr,
    input  wire logic [AW-1:0]         waddr,
    input  wire logic [LANES*LW-1:0]   wdata,
    output var  logic [LANES*LW-1:0]   rdata
);
    logic [LANES*LW-1:0] mem [0:(1<<AW)-1];

    // Each lane holds a data byte and its parity bit together
    // One process owns the whole array; split writers would be multiple drivers
    always_ff @(posedge clk) begin
        if (we) begin
            for (int i = 0; i < LANES; i++) begin
                if (lane_en[i]) begin
                    mem[waddr][i*LW +: LW] <= wdata[i*LW +: LW];
                end
            end
        end
    end

    // Registered read port on its own address; no reset so contents persist
    always_ff @(posedge clk) begin
        rdata <= mem[addr];
    end
endmodule : sram_array
`default_nettype wire

// >>> mem_ctl_model.sv
// Far-side controller model: drives data and parity lines
`timescale 1ns/1ps
`default_nettype none
module mem_ctl_model (
    input  wire logic        clk,
    input  wire logic        drive,
    input  wire logic [35:0] wdata,
    input  wire logic        dut_oe,
    output var  logic [35:0] line_val
);
    logic [35:0] last_r = 36'h0;
    // Released lines toggle so a stale value can never pass for data
    always_ff @(posedge clk) begin
        last_r <= line_val;
    end
    // Drive only in the write data phase, never against the device
    always_comb begin
        line_val = (drive && !dut_oe) ? wdata : ~last_r;
    end
endmodule : mem_ctl_model
`default_nettype wire

// >>> sync_sram_pin_control_tb_top.sv
// Bench: random writes, bursts, qualifier holds and sleep
`timescale 1ns/1ps
`default_nettype none
module sync_sram_pin_control_tb_top;
    import sram_ctl_pkg::*;
    localparam ctl_pins_t LD_RD = 5'h09;
    localparam ctl_pins_t LD_WR = 5'h08;
    localparam ctl_pins_t ADV = 5'h0B;
    localparam ctl_pins_t DESEL = 5'h15;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic qual_n = 1'b0;
    logic oe_n = 1'b0;
    logic slp = 1'b0;
    logic slp_oe = 1'b1;
    logic mode = 1'b0;
    logic mode_oe = 1'b1;
    logic drive = 1'b0;
    ctl_pins_t ctl = DESEL;
    logic [7:0] addr = 8'h00;
    logic [3:0] bwn = 4'hF;
    logic [35:0] wdata = 36'h0;
    logic [35:0] line_val;
    logic [35:0] shadow [256];
    logic [31:0] dq_o;
    logic [3:0] par_o;
    logic dq_oe;
    logic par_oe;
    logic sleeping;
    int n_mismatch = 0;
    int check_count = 0;
    int cyc = 0;

    sync_sram_pin_control dut_u (
        .REF_CLK(clk), .RESETN(rst_n), .CTL(ctl), .CLK_QUALIFY_N(qual_n),
        .ADDR(addr), .BYTE_WR_N(bwn), .OUT_EN_N(oe_n), .SLEEP_REQ(slp),
        .SLEEP_REQ_OE(slp_oe), .BURST_MODE(mode), .BURST_MODE_OE(mode_oe),
        .DQ_I(line_val[31:0]), .DQ_O(dq_o), .DQ_OE(dq_oe),
        .PARITY_IO_I(line_val[35:32]), .PARITY_IO_O(par_o),
        .PARITY_IO_OE(par_oe), .SLEEPING(sleeping));
    mem_ctl_model ctl_u (.clk(clk), .drive(drive), .wdata(wdata), .dut_oe(dq_oe),
        .line_val(line_val));

    initial begin
        forever #5 clk = ~clk;
    end
    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 4000) begin
            n_mismatch++;
            final_report();
        end
    end

    task automatic final_report();
        if (n_mismatch == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : final_report

    task automatic check(input string what, input logic [35:0] seen, input logic [35:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Strap low and driven is linear, else interleaved
    function automatic logic [1:0] bseq(input logic [1:0] b, input logic [1:0] k);
        return (mode_oe && !mode) ? b + k : b ^ k;
    endfunction : bseq

    // One edge: drive next values, return once outputs have settled
    task automatic go(input ctl_pins_t c, input logic [7:0] a, input logic [3:0] b,
                      input logic d, input logic [35:0] wd, input logic q);
        @(posedge clk);
        ctl <= c;
        addr <= a;
        bwn <= b;
        drive <= d;
        wdata <= wd;
        qual_n <= q;
        #1;
    endtask : go

    task automatic wr(input ctl_pins_t c, input logic [7:0] a, input logic [35:0] d,
                      input logic [3:0] b);
        go(c, a, 4'hF, 1'b0, d, 1'b0);
        go(DESEL, a, b, 1'b1, d, 1'b0);
        check("write drive", {34'h0, par_oe, dq_oe}, 36'h0);
        go(DESEL, a, 4'hF, 1'b0, d, 1'b0);
        for (int g = 0; g < 4; g++) begin
            if (c == LD_WR && !b[g]) begin
                shadow[a][8*g +: 8] = d[8*g +: 8];
                shadow[a][32+g] = d[32+g];
            end
        end
    endtask : wr

    // Burst of four with a qualifier hold inside the second beat
    task automatic rd(input logic [7:0] a, input int r, input logic o);
        ctl_pins_t c;
        int nh;
        @(posedge clk);
        oe_n <= o;
        go(LD_RD, a, 4'hF, 1'b0, 36'h0, 1'b0);
        for (int k = 0; k < 4; k++) begin
            nh = (k == 1) ? r : 0;
            for (int h = 0; h <= nh; h++) begin
                c = (h < nh || k == 3) ? DESEL : ADV;
                go(c, a, 4'hF, 1'b0, 36'h0, h < nh);
                check("read data", {par_o, dq_o}, shadow[{a[7:2], bseq(a[1:0], 2'(k))}]);
                check("read drive", {34'h0, par_oe, dq_oe}, {34'h0, {2{k != 0 && !o}}});
            end
        end
    endtask : rd

    initial begin
        logic [5:0] blk;
        void'($urandom(32'hFA0F));
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        for (int t = 0; t < 9; t++) begin
            blk = 6'($urandom);
            for (int i = 0; i < 4; i++)
                wr(LD_WR, {blk, 2'(i)}, {$urandom, 4'($urandom)}, 4'h0);
            wr(LD_WR, {blk, 2'(t)}, {$urandom, 4'($urandom)}, 4'($urandom));
            wr(LD_WR ^ ctl_pins_t'(5'h10 >> (t % 3)), {blk, 2'(t + 1)}, 36'hF_FFFF_FFFF, 4'h0);
            @(posedge clk);
            mode <= (t % 3) == 1;
            mode_oe <= (t % 3) != 2;
            go(DESEL, 8'h00, 4'hF, 1'b0, 36'h0, 1'b0);
            rd({blk, 2'($urandom)}, 1 + $urandom % 3, t > 6);
        end
        @(posedge clk);
        slp <= 1'b1;
        for (int n = 0; n < 8 && sleeping !== 1'b1; n++)
            go(DESEL, 8'h00, 4'hF, 1'b0, 36'h0, 1'b0);
        check("sleep enter", {35'h0, sleeping}, 36'h1);
        @(posedge clk);
        slp_oe <= 1'b0;
        for (int n = 0; n < 8 && sleeping !== 1'b0; n++)
            go(DESEL, 8'h00, 4'hF, 1'b0, 36'h0, 1'b0);
        check("sleep exit", {35'h0, sleeping}, 36'h0);
        repeat (4) go(DESEL, 8'h00, 4'hF, 1'b0, 36'h0, 1'b0);
        rd({blk, 2'h0}, 1, 1'b0);
        final_report();
    end
endmodule : sync_sram_pin_control_tb_top
`default_nettype wire
